// ---- rtl/flash_sector_lock_and_pointer_region.sv ----
// Array write protection: volatile lock bits ORed with a pointer region.
// Assumes a command decoder on clk delivering one command per cycle, and
// a legacy block decoder giving legacyHit for the current command address.
//
// Summary of operation
// - Volatile lock bit per sector or block
// - Sector or global lock writes zero
// - Sector or global unlock writes one
// - Lock read returns addressed lock bit
// - Bits cover blocks and end-block sectors
// - Locked target rejects program and erase
// - Boot bit one: all locked after reset
// - Boot bit zero: all unlocked after reset
// - Pointer ORed with legacy or lock bits
// - Pointer set by FBh, E3h or 71h
// - Stored bit 10 one disables pointer
// - Reserved pointer bits read as ones
// - Boundary from upper address bits, exclusive
// - Bit 9 picks unprotected side
// - Bit 11 protects every sector
// - Set pointer ignored while suspended
// - Set pointer ignored when region locked
// - Read any register 65h returns pointer
// - Erase overlapping pointer region fails
// - Chip erase ignored when protected, error flag set
// - Pointer register write locked when flag is low
// - Lock boot bit is config bit four
`default_nettype none

module flash_sector_lock_and_pointer_region #(
  parameter int          NUM_BLOCKS = flash_prot_pkg::BLOCK_COUNT,
  parameter logic [31:0] PTR_INIT   = flash_prot_pkg::PTR_DEFAULT
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire flash_prot_pkg::cmd_t      cmd,
  input  wire logic                      swResetReq,
  input  wire logic                      addr4Mode,
  input  wire logic                      protSelect,
  input  wire logic                      regionLockFlag,
  input  wire logic                      opSuspended,
  input  wire logic [7:0]                protCfgOtp,
  input  wire logic                      legacyHit,
  input  wire logic                      errClear,
  output flash_prot_pkg::rsp_t           rsp,
  output flash_prot_pkg::verdict_t       verdict,
  output logic                           eraseErr
);
  import flash_prot_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0]       ptrReg_ff;
  rsp_t              rsp_ff;
  verdict_t          verdict_ff;
  logic              eraseErr_ff;
  logic              isSetPtr;
  logic              isWrAnyPtr;
  logic              isRdAnyPtr;
  logic              isSectLock;
  logic              isSectUnlock;
  logic              isGlobLock;
  logic              isGlobUnlock;
  logic              isLockRd;
  logic              isProg;
  logic              isErase;
  logic              isChip;
  logic              isArrayOp;
  logic              ptrWriteOk;
  logic [31:0]       ptrSrc;
  logic [31:0]       nxt_ptrReg;
  logic [12:0]       span;
  logic [12:0]       sect;
  logic [12:0]       rngLo;
  logic [12:0]       rngHi;
  logic              lockBoot;
  logic              rdBit;
  logic              rngLocked;
  logic              anyLocked;
  logic              allLocked;
  logic              ptrEnabled;
  logic              ptrHit;
  logic              otherHit;
  logic              targetProt;
  logic              chipProt;
  logic              rejectNow;
  logic              setErr;
  rsp_t              nxt_rsp;

  // Opcode match for a valid command
  function automatic logic opIs(input cmd_t c, input logic [7:0] code);
    return c.valid && (c.op == code);
  endfunction

  // ****************************************
  // Command decode
  // ****************************************
  // Command classes
  assign isSetPtr     = opIs(cmd, OP_SET_PTR) | opIs(cmd, OP_SET_PTR_WIDE);
  assign isWrAnyPtr   = opIs(cmd, OP_WRITE_ANY) && cmd.addr == PTR_REG_ADDR;
  assign isRdAnyPtr   = opIs(cmd, OP_READ_ANY) && cmd.addr == PTR_REG_ADDR;
  assign isSectLock   = opIs(cmd, OP_SECT_LOCK);
  assign isSectUnlock = opIs(cmd, OP_SECT_UNLOCK);
  assign isGlobLock   = opIs(cmd, OP_GLOB_LOCK);
  assign isGlobUnlock = opIs(cmd, OP_GLOB_UNLOCK);
  assign isLockRd     = opIs(cmd, OP_LOCK_READ);
  assign isProg       = opIs(cmd, OP_PROGRAM);
  assign isErase      = opIs(cmd, OP_ERASE_4K) | opIs(cmd, OP_ERASE_32K) | opIs(cmd, OP_ERASE_64K);
  assign isChip       = opIs(cmd, OP_CHIP_ERASE);
  assign isArrayOp    = isProg | isErase | isChip;

  // Sector range touched by the command
  assign span  = opIs(cmd, OP_ERASE_64K) ? SPAN_64K :
                 opIs(cmd, OP_ERASE_32K) ? SPAN_32K : SPAN_4K;
  assign sect  = cmd.addr[SECT_HI:SECT_LO];
  assign rngLo = sect & ~span;
  assign rngHi = sect | span;

  // ****************************************
  // Pointer region register
  // ****************************************
  // Pointer write acceptance and value
  assign ptrWriteOk = regionLockFlag &
                      (isWrAnyPtr | (isSetPtr & ~opSuspended));
  assign ptrSrc     = isWrAnyPtr ? cmd.data :
                      (opIs(cmd, OP_SET_PTR) && !addr4Mode) ? (cmd.addr & ADDR3_MASK) :
                      cmd.addr;
  assign nxt_ptrReg = ptrWriteOk ? ((ptrSrc & PTR_WR_MASK) | PTR_RSVD_ONES) : ptrReg_ff;

  // Stored image; software reset leaves it alone
  always_ff @(posedge clk)
  begin
    if (srst)
      ptrReg_ff <= PTR_INIT | PTR_RSVD_ONES;
    else
      ptrReg_ff <= nxt_ptrReg;
  end

  pointer_region_check u_ptr (
    .ptrReg     (ptrReg_ff),
    .rngLo      (rngLo),
    .rngHi      (rngHi),
    .ptrEnabled (ptrEnabled),
    .ptrHit     (ptrHit)
  );

  // ****************************************
  // Lock bits
  // ****************************************
  assign lockBoot = protCfgOtp[LOCK_BOOT_POS];

  lock_bit_array #(
    .NUM_BLOCKS (NUM_BLOCKS)
  ) u_lock (
    .clk        (clk),
    .srst       (srst),
    .swReset    (swResetReq),
    .lockBoot   (lockBoot),
    .lockAll    (isGlobLock),
    .unlockAll  (isGlobUnlock),
    .writeOne   (isSectLock | isSectUnlock),
    .writeVal   (isSectUnlock),
    .wrSect     (sect),
    .rdSect     (sect),
    .rngLo      (rngLo),
    .rngHi      (rngHi),
    .rdBit      (rdBit),
    .rngLocked  (rngLocked),
    .anyLocked  (anyLocked),
    .allLocked  (allLocked)
  );

  // ****************************************
  // Protection verdict
  // ****************************************
  // Combined protection of the target
  assign otherHit   = protSelect ? rngLocked : legacyHit;
  assign targetProt = ptrHit | otherHit;
  assign chipProt   = ptrEnabled | (protSelect ? anyLocked : legacyHit);
  assign rejectNow  = isChip ? chipProt : targetProt;
  assign setErr     = (isErase | isChip) & rejectNow;

  // Grant or reject one cycle after the request
  always_ff @(posedge clk)
  begin
    if (srst)
      verdict_ff <= '0;
    else
    begin
      verdict_ff.grant  <= isArrayOp & ~rejectNow;
      verdict_ff.reject <= isArrayOp & rejectNow;
    end
  end

  // Sticky erase error, set wins over clear
  always_ff @(posedge clk)
  begin
    if (srst)
      eraseErr_ff <= 1'b0;
    else
      eraseErr_ff <= (eraseErr_ff & ~errClear) | setErr;
  end

  // ****************************************
  // Read responses
  // ****************************************
  assign nxt_rsp.valid = isLockRd | isRdAnyPtr;
  assign nxt_rsp.data  = isRdAnyPtr ? ptrReg_ff : {31'h0000_0000, rdBit};

  always_ff @(posedge clk)
  begin
    if (srst)
      rsp_ff <= '0;
    else
      rsp_ff <= nxt_rsp;
  end

  assign rsp      = rsp_ff;
  assign verdict  = verdict_ff;
  assign eraseErr = eraseErr_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_PTR_REGION_LOCKED: assert property (
    isSetPtr && !regionLockFlag |=> $stable(ptrReg_ff))
    else $error("pointer changed while region locked");

  AST_PTR_SUSPENDED: assert property (
    isSetPtr && opSuspended |=> $stable(ptrReg_ff))
    else $error("pointer changed during suspend");

  AST_PTR_RSVD_ONES: assert property (
    (rsp.data & PTR_RSVD_ONES) == PTR_RSVD_ONES || !$past(isRdAnyPtr))
    else $error("reserved pointer bits not one");

  AST_WRITE_ANY_REG_CMD_STORES: assert property (
    isWrAnyPtr && regionLockFlag |=>
      ptrReg_ff[31:PTR_DIR_BIT] == $past(cmd.data[31:PTR_DIR_BIT]))
    else $error("write any register did not store pointer");

  AST_READ_ANY: assert property (
    isRdAnyPtr |=> rsp.valid && rsp.data == $past(ptrReg_ff))
    else $error("pointer read returned wrong value");

  AST_CHIP_ERASE_PRP: assert property (
    isChip && ptrEnabled |=> verdict.reject && !verdict.grant && eraseErr)
    else $error("chip erase not refused under pointer protection");

  AST_LOCKED_REJECT: assert property (
    isArrayOp && !isChip && protSelect && rngLocked |=> verdict.reject)
    else $error("locked target was not rejected");

  AST_PTR_DISABLED: assert property (
    ptrReg_ff[PTR_DIS_BIT] && isArrayOp && !isChip && !otherHit |=> verdict.grant && !verdict.reject)
    else $error("disabled pointer still protects");

  AST_PTR_ALL: assert property (
    !ptrReg_ff[PTR_DIS_BIT] && ptrReg_ff[PTR_ALL_BIT] && isArrayOp |=> verdict.reject)
    else $error("protect-all pointer let an operation through");

  AST_ERASE_PTR_FAIL: assert property (
    isErase && ptrHit |=> verdict.reject && eraseErr)
    else $error("erase overlapping pointer region not failed");

  AST_GLOBAL_LOCK: assert property (
    isGlobLock && !swResetReq |=> allLocked)
    else $error("global lock did not lock");

  AST_GLOBAL_UNLOCK: assert property (
    isGlobUnlock && !swResetReq |=> !anyLocked)
    else $error("global unlock did not unlock");

  AST_BOOT_LOCKED: assert property (
    swResetReq && lockBoot |=> allLocked)
    else $error("reset did not lock all bits");

  AST_BOOT_UNLOCKED: assert property (
    swResetReq && !lockBoot |=> !anyLocked)
    else $error("reset did not unlock all bits");

  AST_ERR_STICKY: assert property (
    eraseErr && !errClear |=> eraseErr)
    else $error("erase error dropped without clear");

  // Main scenarios
  CVR_CHIP_PRP:    cover property (isChip && ptrEnabled);
  CVR_UNLOCK_PROG: cover property (isGlobUnlock ##[2:8] isProg ##1 verdict.grant);
  CVR_ERASE_PTR:   cover property (isErase && ptrHit && !otherHit);
  CVR_PTR_SET:     cover property (isSetPtr && ptrWriteOk);

endmodule // flash_sector_lock_and_pointer_region

`default_nettype wire

// ---- rtl/flash_prot_pkg.sv ----
// Constants, opcodes and carrier types for the sector lock and pointer region block.
// Assumes a command decoder in front that delivers whole commands, one per cycle.
`default_nettype none

package flash_prot_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int          BLOCK_COUNT  = 512;
  localparam int          SUB_COUNT    = 16;
  localparam int          SECT_LO      = 12;
  localparam int          SECT_HI      = 24;
  localparam int          SECT_W       = 13;
  localparam int          IDX_W        = 10;
  localparam logic [9:0]  TOP_SUB_BASE = 10'h010;
  localparam logic [9:0]  BLK_BASE     = 10'h020;
  localparam logic [12:0] SPAN_4K      = 13'h0000;
  localparam logic [12:0] SPAN_32K     = 13'h0007;
  localparam logic [12:0] SPAN_64K     = 13'h000F;
  localparam logic        LOCKED       = 1'b0;
  localparam logic        UNLOCKED     = 1'b1;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_SET_PTR      = 8'hFB;
  localparam logic [7:0] OP_SET_PTR_WIDE = 8'hE3;
  localparam logic [7:0] OP_WRITE_ANY    = 8'h71;
  localparam logic [7:0] OP_READ_ANY     = 8'h65;
  localparam logic [7:0] OP_CHIP_ERASE   = 8'hCE;
  localparam logic [7:0] OP_SECT_LOCK    = 8'hA1;
  localparam logic [7:0] OP_SECT_UNLOCK  = 8'hA2;
  localparam logic [7:0] OP_GLOB_LOCK    = 8'hA3;
  localparam logic [7:0] OP_GLOB_UNLOCK  = 8'hA4;
  localparam logic [7:0] OP_LOCK_READ    = 8'hA5;
  localparam logic [7:0] OP_PROGRAM      = 8'hB1;
  localparam logic [7:0] OP_ERASE_4K     = 8'hB2;
  localparam logic [7:0] OP_ERASE_32K    = 8'hB3;
  localparam logic [7:0] OP_ERASE_64K    = 8'hB4;

  // ****************************************
  // Pointer register layout
  // ****************************************
  localparam logic [31:0] PTR_REG_ADDR   = 32'h0000_0100;
  localparam int          PTR_DIR_BIT    = 9;
  localparam int          PTR_DIS_BIT    = 10;
  localparam int          PTR_ALL_BIT    = 11;
  localparam logic [31:0] PTR_WR_MASK    = 32'hFFFF_FE00;
  localparam logic [31:0] PTR_RSVD_ONES  = 32'h0000_01FF;
  localparam logic [31:0] PTR_DEFAULT    = 32'hFFFF_FFFF;
  localparam logic [31:0] ADDR3_MASK     = 32'h00FF_FFFF;
  localparam int          LOCK_BOOT_POS  = 4;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [7:0]  op;
    logic [31:0] addr;
    logic [31:0] data;
  } cmd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } rsp_t;

  typedef struct packed {
    logic grant;
    logic reject;
  } verdict_t;

endpackage : flash_prot_pkg

`default_nettype wire

// ---- rtl/lock_bit_array.sv ----
// Volatile per-sector and per-block lock bits with read and range lookup.
// Assumes set, clear and write requests never coincide.
`default_nettype none

module lock_bit_array #(
  parameter int NUM_BLOCKS = flash_prot_pkg::BLOCK_COUNT
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        swReset,
  input  wire logic        lockBoot,
  input  wire logic        lockAll,
  input  wire logic        unlockAll,
  input  wire logic        writeOne,
  input  wire logic        writeVal,
  input  wire logic [12:0] wrSect,
  input  wire logic [12:0] rdSect,
  input  wire logic [12:0] rngLo,
  input  wire logic [12:0] rngHi,
  output logic             rdBit,
  output logic             rngLocked,
  output logic             anyLocked,
  output logic             allLocked
);
  import flash_prot_pkg::*;

  localparam int LOCK_BITS = NUM_BLOCKS + 2 * SUB_COUNT;

  logic [LOCK_BITS-1:0] lockBits_ff;

  // Maps a 4KB sector number to its lock bit
  function automatic logic [IDX_W-1:0] lockIndex(input logic [SECT_W-1:0] sect);
    logic [8:0] blk;
    blk = sect[SECT_W-1:4];
    if (blk == 9'h000)
      return {6'h00, sect[3:0]};
    else if (blk == 9'(NUM_BLOCKS - 1))
      return TOP_SUB_BASE + {6'h00, sect[3:0]};
    else
      return BLK_BASE + {1'b0, blk};
  endfunction

  // Lock bit storage and updates
  always_ff @(posedge clk)
  begin
    if (srst || swReset)
      lockBits_ff <= {LOCK_BITS{~lockBoot}};
    else if (lockAll)
      lockBits_ff <= {LOCK_BITS{LOCKED}};
    else if (unlockAll)
      lockBits_ff <= {LOCK_BITS{UNLOCKED}};
    else if (writeOne)
      lockBits_ff[lockIndex(wrSect)] <= writeVal;
  end

  // Lookups
  assign rdBit     = lockBits_ff[lockIndex(rdSect)];
  assign anyLocked = ~(&lockBits_ff);
  assign allLocked = ~(|lockBits_ff);

  // Any locked sector inside an aligned range of one block
  always_comb
  begin
    rngLocked = 1'b0;
    for (int i = 0; i < SUB_COUNT; i++)
    begin
      if (4'(i) >= rngLo[3:0] && 4'(i) <= rngHi[3:0] &&
          lockBits_ff[lockIndex({rngLo[SECT_W-1:4], 4'(i)})] == LOCKED)
        rngLocked = 1'b1;
    end
  end

endmodule // lock_bit_array

`default_nettype wire

// ---- rtl/pointer_region_check.sv ----
// Decides whether a sector range touches the pointer-protected region.
// Assumes the pointer register image is stable during the lookup cycle.
`default_nettype none

module pointer_region_check (
  input  wire logic [31:0] ptrReg,
  input  wire logic [12:0] rngLo,
  input  wire logic [12:0] rngHi,
  output logic             ptrEnabled,
  output logic             ptrHit
);
  import flash_prot_pkg::*;

  logic [SECT_W-1:0] ptrSect;
  logic              belowProt;
  logic              aboveProt;

  // Region decode
  assign ptrEnabled = ~ptrReg[PTR_DIS_BIT];
  assign ptrSect    = ptrReg[SECT_HI:SECT_LO];
  assign aboveProt  = rngHi > ptrSect;
  assign belowProt  = rngLo < ptrSect;
  assign ptrHit     = ptrEnabled & (ptrReg[PTR_ALL_BIT] |
                      (ptrReg[PTR_DIR_BIT] ? belowProt : aboveProt));

endmodule // pointer_region_check

`default_nettype wire

// ---- verif/flash_host_model.sv ----
// Host controller model: sends one command on the command port
// and collects the answer. Assumes clk comes from the bench.
`default_nettype none

module flash_host_model (
  input  wire logic                     clk,
  output var  flash_prot_pkg::cmd_t     cmd,
  output var  logic                     addr4Mode,
  input  wire flash_prot_pkg::rsp_t     rsp,
  input  wire flash_prot_pkg::verdict_t verdict
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_prot_pkg::*;

  // Idle bus, narrow addressing out of reset
  initial
  begin
    cmd       = '0;
    addr4Mode = 1'b0;
  end

  // ****************************************
  // Command transfer
  // ****************************************
  // Answer is sampled 1 ns after the edge that takes the command
  task automatic xfer(input logic [7:0] op, input logic [31:0] a, input logic [31:0] d,
                      output rsp_t r, output verdict_t v);
    if (!addr4Mode && (op == OP_SET_PTR || op == OP_SET_PTR_WIDE || op == OP_WRITE_ANY))
    begin
      @(posedge clk);
      #1 addr4Mode = 1'b1;
    end
    @(posedge clk);
    #1 cmd = '{valid: 1'b1, op: op, addr: a, data: d};
    @(posedge clk);
    #1 cmd = '{valid: 1'b0, op: ~op, addr: ~a, data: ~d}; // Stale fields scrambled
    r = rsp;
    v = verdict;
  endtask
endmodule // flash_host_model

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the sector lock and pointer region block.
// Assumes the package and the host model are compiled first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_prot_pkg::*;

  localparam logic [31:0] P = 32'h0010_5000;
  logic        clk, srst, swResetReq, addr4Mode, protSelect, regionLockFlag;
  logic        opSuspended, legacyHit, errClear, eraseErr;
  logic [7:0]  protCfgOtp;
  logic [31:0] val;
  logic [2:0]  g;
  cmd_t        cmd;
  rsp_t        rsp, r;
  verdict_t    verdict, v;
  int          miscompares, n_tests;

  flash_sector_lock_and_pointer_region uut (
    .clk(clk), .srst(srst), .cmd(cmd), .swResetReq(swResetReq), .addr4Mode(addr4Mode),
    .protSelect(protSelect), .regionLockFlag(regionLockFlag), .opSuspended(opSuspended),
    .protCfgOtp(protCfgOtp), .legacyHit(legacyHit), .errClear(errClear),
    .rsp(rsp), .verdict(verdict), .eraseErr(eraseErr)
  );

  flash_host_model host (
    .clk(clk), .cmd(cmd), .addr4Mode(addr4Mode), .rsp(rsp), .verdict(verdict)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] op, input logic [31:0] a, input logic [31:0] d);
    host.xfer(op, a, d, r, v);
  endtask

  task automatic rdLock(input logic [31:0] a, input logic b);
    send(OP_LOCK_READ, a, 32'h0);
    check(r, {1'b1, 31'h0, b});
  endtask

  task automatic rdPtr(input logic [31:0] e);
    send(OP_READ_ANY, PTR_REG_ADDR, 32'h0);
    check(r, {1'b1, e});
  endtask

  task automatic act(input logic [7:0] op, input logic [31:0] a, input logic ok);
    send(op, a, 32'h0);
    check({31'h0, v}, {31'h0, ok, ~ok});
  endtask

  task automatic errIs(input logic e);
    check({32'h0, eraseErr}, {32'h0, e});
  endtask

  task automatic clrErr;
    errClear = 1'b1;
    tick;
    errClear = 1'b0;
    errIs(1'b0);
  endtask

  task automatic swPulse(input logic boot);
    protCfgOtp[LOCK_BOOT_POS] = boot;
    swResetReq = 1'b1;
    tick;
    swResetReq = 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    {srst, swResetReq, protSelect, regionLockFlag} = 4'hB;
    {opSuspended, legacyHit, errClear} = 3'h0;
    protCfgOtp = 8'hFF;
    miscompares = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    rdLock(32'h0005_0000, 1'b0);
    rdLock(32'h01FF_F000, 1'b0);
    rdPtr(32'hFFFF_FFFF);
    act(OP_PROGRAM, 32'h0005_0000, 1'b0);
    errIs(1'b0);
    send(OP_GLOB_UNLOCK, 32'h0, 32'h0);
    rdLock(32'h0005_0000, 1'b1);
    act(OP_PROGRAM, 32'h0005_0000, 1'b1);
    send(OP_SECT_LOCK, 32'h0005_0000, 32'h0);
    rdLock(32'h0005_0000, 1'b0);
    rdLock(32'h0006_0000, 1'b1);
    act(OP_ERASE_64K, 32'h0005_0000, 1'b0);
    errIs(1'b1);
    clrErr;
    send(OP_SECT_UNLOCK, 32'h0005_0000, 32'h0);
    rdLock(32'h0005_0000, 1'b1);
    send(OP_SECT_LOCK, 32'h0000_3000, 32'h0);
    rdLock(32'h0000_3000, 1'b0);
    rdLock(32'h0000_4000, 1'b1);
    act(OP_ERASE_4K, 32'h0000_4000, 1'b1);
    act(OP_ERASE_64K, 32'h0000_0000, 1'b0);
    send(OP_GLOB_LOCK, 32'h0, 32'h0);
    rdLock(32'h0006_0000, 1'b0);
    send(OP_GLOB_UNLOCK, 32'h0, 32'h0);
    swPulse(1'b1);
    rdLock(32'h0006_0000, 1'b0);
    swPulse(1'b0);
    rdLock(32'h0006_0000, 1'b1);
    rdLock(32'h0000_3000, 1'b1);
    // Legacy selection ignores lock bits
    protSelect = 1'b0;
    send(OP_SECT_LOCK, 32'h0005_0000, 32'h0);
    act(OP_PROGRAM, 32'h0005_0000, 1'b1);
    legacyHit = 1'b1;
    act(OP_PROGRAM, 32'h0006_0000, 1'b0);
    legacyHit = 1'b0;
    protSelect = 1'b1;
    act(OP_PROGRAM, 32'h0005_0000, 1'b0);
    send(OP_SECT_UNLOCK, 32'h0005_0000, 32'h0);
    clrErr;
    // Pointer above, below and all-protected, one per write command
    for (int i = 0; i < 3; i++)
    begin
      val = P | {20'h0, i[1], 1'b0, i[0], 9'h0};
      g = (i == 0) ? 3'b101 : (i == 1) ? 3'b110 : 3'b000;
      if (i == 2)
        send(OP_WRITE_ANY, PTR_REG_ADDR, val);
      else
        send((i == 0) ? OP_SET_PTR : OP_SET_PTR_WIDE, val, 32'h0);
      rdPtr((val & 32'hFFFF_FE00) | 32'h0000_01FF);
      act(OP_PROGRAM, P, g[2]);
      act(OP_PROGRAM, P + 32'h1000, g[1]);
      act(OP_PROGRAM, P - 32'h1000, g[0]);
      act(OP_ERASE_32K, 32'h0010_0000, 1'b0);
      errIs(1'b1);
      clrErr;
    end
    act(OP_CHIP_ERASE, 32'h0, 1'b0);
    errIs(1'b1);
    clrErr;
    regionLockFlag = 1'b0;
    send(OP_SET_PTR, 32'h0, 32'h0);
    send(OP_WRITE_ANY, PTR_REG_ADDR, 32'h0);
    rdPtr(32'h0010_59FF);
    regionLockFlag = 1'b1;
    opSuspended = 1'b1;
    send(OP_SET_PTR_WIDE, 32'h0, 32'h0);
    rdPtr(32'h0010_59FF);
    opSuspended = 1'b0;
    send(OP_WRITE_ANY, PTR_REG_ADDR, 32'hFFFF_FFFF);
    rdPtr(32'hFFFF_FFFF);
    act(OP_CHIP_ERASE, 32'h0, 1'b1);
    tally_and_finish;
  end

  // Watchdog, about twenty times the expected run length
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule // testbench

`default_nettype wire
